// ### rtl/pull_range_pkg.sv
// Purpose: Shared constants and carriers of the DPLL pull-in range limit block.
// Assumes: Frequency offsets are signed counts in steps of 0.01 of the offset unit.
// Notes: Register byte address is four times the register index.
package pull_range_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_LOW = 8'h41;
    localparam logic [7:0] IDX_HIGH = 8'h42;
    localparam logic [7:0] IDX_STATUS = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_LOW = {2'h0, IDX_LOW, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_HIGH = {2'h0, IDX_HIGH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [7:0] LOW_RESET = 8'h00;
    localparam logic [1:0] HIGH_RESET = 2'h0;
    localparam int HIGH_FIELD_W = 2;
    localparam int STAT_MAIN_BIT = 0;
    localparam int STAT_AUX_BIT = 1;

    // ********************************************************************
    // Limit arithmetic
    // ********************************************************************
    localparam int LIMIT_W = 10;
    localparam int BOUND_W = 14;
    localparam int OFFSET_W = 16;
    localparam int SUM_W = 17;
    // One limit step is 0.07, held as 7 steps of 0.01.
    localparam logic [3:0] LIMIT_SCALE = 4'h7;

    // ********************************************************************
    // Bus answers
    // ********************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    typedef struct packed {
        logic signed [OFFSET_W-1:0] main_loop;
        logic signed [OFFSET_W-1:0] aux_loop;
    } loop_offset_s;

    typedef struct packed {
        logic signed [SUM_W-1:0] main_loop;
        logic signed [SUM_W-1:0] aux_loop;
    } loop_result_s;

endpackage : pull_range_pkg

// ### rtl/pull_range_bound.sv
// Purpose: Turns the two limit register fields into the offset bound.
// Assumes: Fields come from registers on the same clock.
// Notes: Bound is registered, so it follows a register write by one cycle.
`timescale 1ns/1ps
module pull_range_bound
    import pull_range_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] high_field,
    input wire logic [7:0] low_field,
    output logic [pull_range_pkg::BOUND_W-1:0] bound
);
    typedef struct packed {
        logic [BOUND_W-1:0] bound;
    } state_s;

    state_s s;
    state_s next_s;
    logic [LIMIT_W-1:0] pull_range_value;

    always_comb begin
        next_s = s;
        pull_range_value = {high_field, low_field};
        next_s.bound = BOUND_W'({4'h0, pull_range_value} * {10'h0, LIMIT_SCALE});
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bound = s.bound;
endmodule : pull_range_bound

// ### rtl/pull_range_clamp.sv
// Purpose: Limits one loop's frequency offset to the symmetric pull-in bound.
// Assumes: Measured offset is taken against the local crystal oscillator.
// Notes: Output is registered one cycle after its inputs.
`timescale 1ns/1ps
module pull_range_clamp
    import pull_range_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic signed [pull_range_pkg::OFFSET_W-1:0] measured,
    input wire logic signed [pull_range_pkg::OFFSET_W-1:0] calibration,
    input wire logic [pull_range_pkg::BOUND_W-1:0] bound,
    output logic signed [pull_range_pkg::SUM_W-1:0] followed,
    output logic clamped
);
    typedef struct packed {
        logic signed [SUM_W-1:0] followed;
        logic clamped;
    } state_s;

    state_s s;
    state_s next_s;
    logic signed [SUM_W-1:0] offset;
    logic signed [SUM_W-1:0] pos_bound;
    logic signed [SUM_W-1:0] neg_bound;

    always_comb begin
        next_s = s;
        offset = SUM_W'(measured) + SUM_W'(calibration);
        pos_bound = $signed({3'h0, bound});
        neg_bound = -pos_bound;
        if (offset > pos_bound) begin
            next_s.followed = pos_bound;
            next_s.clamped = 1'b1;
        end else if (offset < neg_bound) begin
            next_s.followed = neg_bound;
            next_s.clamped = 1'b1;
        end else begin
            next_s.followed = offset;
            next_s.clamped = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign followed = s.followed;
    assign clamped = s.clamped;
endmodule : pull_range_clamp

// ### rtl/dpll_pull_range_limit.sv
// Purpose: Pull-in range limit registers and offset clamps of the main and auxiliary loops.
// Assumes: Loop offsets and calibration come from logic on core_clk.
// Notes: AXI4-Lite slave, one write and one read under way at a time.
//        The byte address of each register is four times its index.
//        A read-only status word shows both clamp flags.
//        Register changes reach the clamps two edges after the write edge.
//
// Contract
// - The limit is the largest offset either loop follows on a reference before limiting.
// - The offset compared against the limit is measured against the crystal oscillator.
// - Nominal-frequency calibration is included in the compared offset automatically.
// - The limit is the high register's two low bits joined above the low register's byte.
// - The offset bound is the limit value times 0.07.
// - The high register is read-write, holds limit bits 9 and 8 and resets to zero.
`timescale 1ns/1ps
module dpll_pull_range_limit
    import pull_range_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire pull_range_pkg::axi_req_s axi_in,
    output pull_range_pkg::axi_rsp_s axi_out,
    input wire pull_range_pkg::loop_offset_s measured,
    input wire logic signed [pull_range_pkg::OFFSET_W-1:0] calibration,
    output pull_range_pkg::loop_result_s followed,
    output logic main_clamped,
    output logic aux_clamped
);

    // ********************************************************************
    // Types and state
    // ********************************************************************
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_e;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b001,
        SEL_LOW = 3'b010,
        SEL_HIGH = 3'b100
    } sel_e;

    // The bus and limit register state, registered once per edge.
    typedef struct packed {
        wr_state_e wr_state;
        rd_state_e rd_state;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [7:0] pull_range_low;
        logic [1:0] pull_range_high;
        axi_rsp_s rsp;
    } state_s;

    // Ready is high in idle so a request is taken at the first edge that offers it.
    localparam state_s RESET_STATE = '{
        wr_state: WR_COLLECT,
        rd_state: RD_IDLE,
        aw_held: 1'b0,
        w_held: 1'b0,
        awaddr: '0,
        wdata: '0,
        wstrb: '0,
        pull_range_low: LOW_RESET,
        pull_range_high: HIGH_RESET,
        rsp: '{
            awready: 1'b1,
            wready: 1'b1,
            bvalid: 1'b0,
            bresp: RESP_OKAY,
            arready: 1'b1,
            rvalid: 1'b0,
            rdata: '0,
            rresp: RESP_OKAY
        }
    };

    state_s s;
    state_s next_s;

    // ********************************************************************
    // Address decode
    // ********************************************************************
    // Anything but the two limit registers decodes to none and answers with an error, except a read of the status word.
    function automatic sel_e decode(input logic [ADDR_W-1:0] addr);
        sel_e sel;
        sel = SEL_NONE;
        if (addr == ADDR_LOW) begin
            sel = SEL_LOW;
        end else if (addr == ADDR_HIGH) begin
            sel = SEL_HIGH;
        end
        return sel;
    endfunction : decode

    // Each limit register is at most one byte wide, so only byte lane 0 of a write counts.
    function automatic logic lane0_written(input logic [3:0] strb);
        return strb[0];
    endfunction : lane0_written

    // The status word sits apart from the limit pair and only answers reads.
    function automatic logic status_hit(input logic [ADDR_W-1:0] addr);
        return addr == ADDR_STATUS;
    endfunction : status_hit

    // ********************************************************************
    // Limit and clamps
    // ********************************************************************
    // The bound is registered and so is each clamp, so a register write reaches
    // the clamped offsets two edges after the write edge.
    logic [BOUND_W-1:0] bound;
    logic main_clamp_flag;
    logic aux_clamp_flag;

    pull_range_bound u_bound (
        .core_clk(core_clk),
        .rst(rst),
        .high_field(s.pull_range_high),
        .low_field(s.pull_range_low),
        .bound(bound)
    );

    // Both loops share one bound and one calibration input.
    // main loop limit
    pull_range_clamp u_main_path_loop (
        .core_clk(core_clk),
        .rst(rst),
        .measured(measured.main_loop),
        .calibration(calibration),
        .bound(bound),
        .followed(followed.main_loop),
        .clamped(main_clamp_flag)
    );

    pull_range_clamp u_auxiliary_path_loop (
        .core_clk(core_clk),
        .rst(rst),
        .measured(measured.aux_loop),
        .calibration(calibration),
        .bound(bound),
        .followed(followed.aux_loop),
        .clamped(aux_clamp_flag)
    );

    // Clamp flags leave the block directly from the clamp registers.
    assign main_clamped = main_clamp_flag;
    assign aux_clamped = aux_clamp_flag;

    // ********************************************************************
    // Bus slave
    // ********************************************************************
    // Every answer signal is a register field, so all outputs come straight from
    // flip-flops. The price is one cycle of latency on each answer and a ready
    // that stays low from the taking edge until the response has been accepted.
    logic aw_take;
    logic w_take;
    logic [ADDR_W-1:0] eff_addr;
    logic [31:0] eff_data;
    logic [3:0] eff_strb;
    // Decoded targets of the write under way and of the offered read.
    sel_e wsel;
    sel_e rsel;

    always_comb begin
        // Fields not named below keep their value.
        next_s = s;
        aw_take = axi_in.awvalid && s.rsp.awready;
        w_take = axi_in.wvalid && s.rsp.wready;
        // An address or data beat taken at this edge is used at once, so a write
        // that offers both together completes in one cycle.
        eff_addr = aw_take ? axi_in.awaddr : s.awaddr;
        eff_data = w_take ? axi_in.wdata : s.wdata;
        eff_strb = w_take ? axi_in.wstrb : s.wstrb;
        wsel = decode(eff_addr);
        rsel = decode(axi_in.araddr);

        // ****************************************************************
        // Write channel
        // ****************************************************************
        unique case (s.wr_state)
            WR_COLLECT: begin
                if (aw_take) begin
                    next_s.aw_held = 1'b1;
                    next_s.awaddr = axi_in.awaddr;
                    next_s.rsp.awready = 1'b0;
                end
                if (w_take) begin
                    next_s.w_held = 1'b1;
                    next_s.wdata = axi_in.wdata;
                    next_s.wstrb = axi_in.wstrb;
                    next_s.rsp.wready = 1'b0;
                end
                if ((aw_take || s.aw_held) && (w_take || s.w_held)) begin
                    next_s.wr_state = WR_RESP;
                    next_s.rsp.bvalid = 1'b1;
                    next_s.rsp.bresp = RESP_OKAY;
                    next_s.rsp.awready = 1'b0;
                    next_s.rsp.wready = 1'b0;
                    unique case (wsel)
                        SEL_LOW: begin
                            if (lane0_written(eff_strb)) begin
                                next_s.pull_range_low = eff_data[7:0];
                            end
                        end
                        SEL_HIGH: begin
                            if (lane0_written(eff_strb)) begin
                                next_s.pull_range_high = eff_data[HIGH_FIELD_W-1:0];
                            end
                        end
                        SEL_NONE: begin
                            // Unmapped or read-only target: nothing is stored.
                            next_s.rsp.bresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            WR_RESP: begin
                // Ready returns only after the response is taken: one write at a time.
                if (axi_in.bready) begin
                    next_s.wr_state = WR_COLLECT;
                    next_s.rsp.bvalid = 1'b0;
                    next_s.aw_held = 1'b0;
                    next_s.w_held = 1'b0;
                    next_s.rsp.awready = 1'b1;
                    next_s.rsp.wready = 1'b1;
                end
            end
            default: begin
                // An illegal state code falls back to idle; its request is lost.
                next_s.wr_state = WR_COLLECT;
            end
        endcase

        // ****************************************************************
        // Read channel
        // ****************************************************************
        // The read decode uses the offered address directly; it is not held.
        unique case (s.rd_state)
            RD_IDLE: begin
                if (axi_in.arvalid) begin
                    next_s.rd_state = RD_DATA;
                    next_s.rsp.arready = 1'b0;
                    next_s.rsp.rvalid = 1'b1;
                    next_s.rsp.rresp = RESP_OKAY;
                    next_s.rsp.rdata = '0;
                    // Flags are sampled at the taking edge and do not clear on read.
                    if (status_hit(axi_in.araddr)) begin
                        next_s.rsp.rdata[STAT_MAIN_BIT] = main_clamp_flag;
                        next_s.rsp.rdata[STAT_AUX_BIT] = aux_clamp_flag;
                    end else begin
                        unique case (rsel)
                            SEL_LOW: begin
                                next_s.rsp.rdata[7:0] = s.pull_range_low;
                            end
                            SEL_HIGH: begin
                                next_s.rsp.rdata[HIGH_FIELD_W-1:0] = s.pull_range_high;
                            end
                            SEL_NONE: begin
                                next_s.rsp.rresp = RESP_SLVERR;
                            end
                        endcase
                    end
                end
            end
            RD_DATA: begin
                // Ready returns only after the data is taken: one read at a time.
                if (axi_in.rready) begin
                    next_s.rd_state = RD_IDLE;
                    next_s.rsp.rvalid = 1'b0;
                    next_s.rsp.arready = 1'b1;
                end
            end
            default: begin
                // An illegal state code falls back to idle; its request is lost.
                next_s.rd_state = RD_IDLE;
            end
        endcase
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    // Reset puts every answer at its idle level before the first request.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign axi_out = s.rsp;

endmodule : dpll_pull_range_limit

// ### bench/pull_range_monitor.sv
// Purpose: Port checker of the pull-in range limit block.
// Assumes: Bound onto dpll_pull_range_limit.
// Notes: Follow checks skip the first edge after reset.
`timescale 1ns/1ps
module pull_range_monitor
    import pull_range_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire pull_range_pkg::axi_req_s axi_in,
    input wire pull_range_pkg::axi_rsp_s axi_out,
    input wire pull_range_pkg::loop_offset_s measured,
    input wire logic signed [pull_range_pkg::OFFSET_W-1:0] calibration,
    input wire pull_range_pkg::loop_result_s followed,
    input wire logic main_clamped,
    input wire logic aux_clamped
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic signed [SUM_W-1:0] m_sum;
    logic signed [SUM_W-1:0] a_sum;
    assign m_sum = measured.main_loop + calibration;
    assign a_sum = measured.aux_loop + calibration;
    // ******************
    // Loop path
    // ******************
    chk_main_follow: assert property (
        !$past(rst) && !main_clamped |-> followed.main_loop == $past(m_sum))
        else $error("main loop offset not followed");
    chk_aux_follow: assert property (
        !$past(rst) && !aux_clamped |-> followed.aux_loop == $past(a_sum))
        else $error("aux loop offset not followed");
    chk_main_clamp: assert property (main_clamped |->
        ($past(m_sum) > 0 && followed.main_loop >= 0 && followed.main_loop < $past(m_sum))
        || ($past(m_sum) < 0 && followed.main_loop <= 0 && followed.main_loop > $past(m_sum)))
        else $error("main clamp wrong");
    chk_aux_clamp: assert property (aux_clamped |->
        ($past(a_sum) > 0 && followed.aux_loop >= 0 && followed.aux_loop < $past(a_sum))
        || ($past(a_sum) < 0 && followed.aux_loop <= 0 && followed.aux_loop > $past(a_sum)))
        else $error("aux clamp wrong");
    // ******************
    // Register bus
    // ******************
    chk_write_answer: assert property (axi_in.awvalid && axi_out.awready
        && axi_in.wvalid && axi_out.wready |=> axi_out.bvalid && !axi_out.awready)
        else $error("write answer late");
    chk_read_answer: assert property (axi_in.arvalid && axi_out.arready
        |=> axi_out.rvalid && !axi_out.arready) else $error("read answer late");
    chk_bvalid_stand: assert property (axi_out.bvalid && !axi_in.bready
        |=> axi_out.bvalid && $stable(axi_out.bresp)) else $error("bvalid dropped");
    chk_rvalid_stand: assert property (axi_out.rvalid && !axi_in.rready
        |=> axi_out.rvalid && $stable(axi_out.rdata)) else $error("rvalid dropped");
    chk_rdata_width: assert property (
        axi_out.rvalid && axi_out.rresp == RESP_OKAY |-> axi_out.rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    cov_write: cover property (axi_out.bvalid && axi_in.bready);
    cov_read: cover property (axi_out.rvalid && axi_in.rready);
    cov_main: cover property (main_clamped);
    cov_aux: cover property (aux_clamped);
endmodule : pull_range_monitor

bind dpll_pull_range_limit pull_range_monitor u_mon (.core_clk(core_clk), .rst(rst),
    .axi_in(axi_in), .axi_out(axi_out), .measured(measured), .calibration(calibration),
    .followed(followed), .main_clamped(main_clamped), .aux_clamped(aux_clamped));

// ### bench/tb_top.sv
// Purpose: Self-checking bench of the pull-in range limit block.
// Assumes: Bus tasks start just after a clock edge.
// Notes: Random offsets come from a fixed seed.
`timescale 1ns/1ps
module tb_top;
    import pull_range_pkg::*;
    logic core_clk;
    logic rst;
    axi_req_s axi_in;
    axi_rsp_s axi_out;
    loop_offset_s measured;
    logic signed [OFFSET_W-1:0] calibration;
    loop_result_s followed;
    logic main_clamped;
    logic aux_clamped;
    int mismatches;
    int total_checks;
    logic [1:0] resp;
    logic [31:0] rd;
    logic [LIMIT_W-1:0] lim;
    logic signed [OFFSET_W-1:0] b;

    dpll_pull_range_limit u_dut (.core_clk(core_clk), .rst(rst), .axi_in(axi_in),
        .axi_out(axi_out), .measured(measured), .calibration(calibration),
        .followed(followed), .main_clamped(main_clamped), .aux_clamped(aux_clamped));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ******************
    // Helpers
    // ******************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude;
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // Answers are sampled settled at the falling edge; the rising edge that follows
    // is the one at which they are taken, so requests change only after it.
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [3:0] s);
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        @(posedge core_clk);
        axi_in.awvalid <= 1'b1;
        axi_in.awaddr <= a;
        axi_in.wvalid <= 1'b1;
        axi_in.wdata <= d;
        axi_in.wstrb <= s;
        axi_in.bready <= 1'b1;
        do begin
            @(negedge core_clk);
            aw_hs = axi_in.awvalid && axi_out.awready === 1'b1;
            w_hs = axi_in.wvalid && axi_out.wready === 1'b1;
            b_hs = axi_out.bvalid === 1'b1;
            if (b_hs) resp = axi_out.bresp;
            @(posedge core_clk);
            if (aw_hs) axi_in.awvalid <= 1'b0;
            if (w_hs) axi_in.wvalid <= 1'b0;
        end while (!b_hs);
        axi_in.bready <= 1'b0;
    endtask : bus_write

    task automatic rd_check(input string what, input logic [ADDR_W-1:0] a,
        input logic [31:0] exp, input logic [1:0] er);
        logic ar_hs;
        logic r_hs;
        @(posedge core_clk);
        axi_in.arvalid <= 1'b1;
        axi_in.araddr <= a;
        axi_in.rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ar_hs = axi_in.arvalid && axi_out.arready === 1'b1;
            r_hs = axi_out.rvalid === 1'b1;
            rd = axi_out.rdata;
            resp = axi_out.rresp;
            @(posedge core_clk);
            if (ar_hs) axi_in.arvalid <= 1'b0;
        end while (!r_hs);
        axi_in.rready <= 1'b0;
        check(what, exp, rd);
        check(what, er, resp);
    endtask : rd_check

    function automatic logic signed [SUM_W-1:0] exp_follow(input logic signed [OFFSET_W-1:0] m,
        input logic signed [OFFSET_W-1:0] c);
        logic signed [SUM_W-1:0] s;
        logic signed [SUM_W-1:0] lb;
        s = m + c;
        lb = lim * 7;
        if (s > lb) return lb;
        if (s < -lb) return -lb;
        return s;
    endfunction : exp_follow

    task automatic loop_case(input logic signed [OFFSET_W-1:0] m,
        input logic signed [OFFSET_W-1:0] x, input logic signed [OFFSET_W-1:0] c);
        logic signed [SUM_W-1:0] em;
        logic signed [SUM_W-1:0] ex;
        @(posedge core_clk);
        measured <= '{m, x};
        calibration <= c;
        @(posedge core_clk);
        #1;
        em = exp_follow(m, c);
        ex = exp_follow(x, c);
        check("main offset", em, followed.main_loop);
        check("main flag", em != m + c, main_clamped);
        check("aux offset", ex, followed.aux_loop);
        check("aux flag", ex != x + c, aux_clamped);
    endtask : loop_case
    // ******************
    // Sequence
    // ******************
    initial begin
        void'($urandom(66));
        rst = 1'b1;
        axi_in = '0;
        measured = '0;
        calibration = '0;
        lim = '0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd_check("low reset", ADDR_LOW, 32'h0, RESP_OKAY);
        rd_check("high reset", ADDR_HIGH, 32'h0, RESP_OKAY);
        rd_check("status reset", ADDR_STATUS, 32'h0, RESP_OKAY);
        bus_write(ADDR_HIGH, 32'hFFFF_FFFF, 4'hF);
        rd_check("high bits", ADDR_HIGH, 32'h3, RESP_OKAY);
        bus_write(ADDR_LOW, 32'h5A, 4'hE);
        rd_check("low strobe", ADDR_LOW, 32'h0, RESP_OKAY);
        bus_write(12'h200, 32'h1, 4'hF);
        check("unmapped write", RESP_SLVERR, resp);
        rd_check("unmapped read", 12'h200, 32'h0, RESP_SLVERR);
        bus_write(ADDR_STATUS, 32'h1, 4'hF);
        check("status write", RESP_SLVERR, resp);
        for (int k = 0; k < 5; k++) begin
            lim = (k == 0) ? 10'h0 : (k == 1) ? 10'h3FF : 10'($urandom());
            b = lim * 7;
            bus_write(ADDR_LOW, {24'h0, lim[7:0]}, 4'h1);
            bus_write(ADDR_HIGH, {30'h0, lim[9:8]}, 4'h1);
            rd_check("limit low", ADDR_LOW, {24'h0, lim[7:0]}, RESP_OKAY);
            rd_check("limit high", ADDR_HIGH, {30'h0, lim[9:8]}, RESP_OKAY);
            loop_case(b, -b, 16'h0);
            loop_case(b, -b, 16'h1);
            loop_case(b + 16'h1, -b - 16'h1, 16'h0);
            rd_check("status flags", ADDR_STATUS, 32'h3, RESP_OKAY);
            repeat (30) begin
                loop_case(16'($urandom_range(0, 20000) - 10000),
                    16'($urandom_range(0, 20000) - 10000), 16'($urandom_range(0, 400) - 200));
            end
        end
        conclude();
    end

    initial begin
        #(20000 * 100);
        mismatches++;
        conclude();
    end
endmodule : tb_top
